// [shared/bcpu_pkg.sv]
// bcpu_pkg: opcodes, status bit positions, reset values, states, bus record
// assumes: shared by the core, the bus sequencer and the bench
package bcpu_pkg;
   localparam int         NREG      = 7;
   localparam int         ADDR_W    = 15;
   // whole opcodes
   localparam logic [7:0] OP_HALT   = 8'h40;
   localparam logic [7:0] OP_NOP    = 8'hC0;
   localparam logic [7:0] OP_SPSU   = 8'h12;
   localparam logic [7:0] OP_SPSL   = 8'h13;
   localparam logic [7:0] OP_LPSU   = 8'h92;
   localparam logic [7:0] OP_LPSL   = 8'h93;
   localparam logic [7:0] OP_TPSU   = 8'hB4;
   localparam logic [7:0] OP_TPSL   = 8'hB5;
   localparam logic [7:0] OP_BSXA   = 8'hBF;
   // opcode bits 7:2 for ops that carry a register, condition or status-select field
   localparam logic [5:0] G_RETC    = 6'h05;
   localparam logic [5:0] G_BCTR    = 6'h06;
   localparam logic [5:0] G_BCTA    = 6'h07;
   localparam logic [5:0] G_REDC    = 6'h0C;
   localparam logic [5:0] G_RETE    = 6'h0D;
   localparam logic [5:0] G_REDE    = 6'h15;
   localparam logic [5:0] G_REDD    = 6'h1C;
   localparam logic [5:0] G_CPPS    = 6'h1D;
   localparam logic [5:0] G_WRTC    = 6'h2C;
   localparam logic [5:0] G_WRTE    = 6'h35;
   localparam logic [5:0] G_WRTD    = 6'h3C;
   // arithmetic group: bits 7:5 op, bits 3:2 mode
   localparam logic [2:0] A_EOR = 3'h1, A_AND = 3'h2, A_IOR = 3'h3, A_ADD = 3'h4;
   localparam logic [2:0] A_SUB = 3'h5, A_STR = 3'h6, A_COM = 3'h7;
   localparam logic [1:0] M_Z = 2'h0, M_I = 2'h1, M_R = 2'h2, M_A = 2'h3;
   localparam logic [1:0] CC_ZERO = 2'h0, CC_POS = 2'h1, CC_NEG = 2'h2, CC_ALWAYS = 2'h3;
   // status upper / lower bit positions
   localparam int         PSU_FLAG  = 6;
   localparam int         PSU_II    = 5;
   localparam int         PSL_CC    = 6;
   localparam int         PSL_IDC   = 5;
   localparam int         PSL_RS    = 4;
   localparam int         PSL_WC    = 3;
   localparam int         PSL_OVF   = 2;
   localparam int         PSL_COM   = 1;
   localparam int         PSL_C     = 0;
   localparam logic [6:0] PSU_WM_EARLY = 7'h67;
   localparam logic [6:0] PSU_WM_LATE  = 7'h7F;
   localparam logic [6:0] PSU_RST_EARLY = 7'h00;
   localparam logic [6:0] PSU_RST_LATE  = 7'h20;
   localparam logic [7:0] RST_PSL   = 8'h00;
   localparam logic [14:0] RST_IAR  = 15'h0000;
   localparam logic       DC_DATA = 1'b1, DC_CTRL = 1'b0, IO_EXT = 1'b1, IO_NONEXT = 1'b0;
   typedef enum logic [2:0] {
      S_FETCH = 3'h0, S_B2 = 3'h1, S_B3 = 3'h3, S_DATA = 3'h2,
      S_EXEC = 3'h6, S_VECT = 3'h7, S_HALT = 3'h5
   } bcpu_st_t;
   typedef enum logic [1:0] {
      B_IDLE = 2'h0, B_SETUP = 2'h1, B_REQ = 2'h3, B_END = 2'h2
   } bcpu_bst_t;
   typedef struct packed {
      logic [14:0] addr;
      logic        mem;
      logic        wr;
      logic        vack;
      logic [7:0]  wdata;
   } bcpu_req_t;
endpackage : bcpu_pkg

// [src/bcpu_ras.sv]
// bcpu_ras: return address stack storage, one write and one read port
// assumes: the core keeps the wraparound level pointer
`timescale 1ns/1ps
module bcpu_ras #(
   parameter int DEPTH = 8,
   parameter int AW    = 15,
   parameter int PW    = 3
) (
   input  wire logic          i_mclk,
   input  wire logic          i_rst,
   input  wire logic          i_we,
   input  wire logic [PW-1:0] i_widx,
   input  wire logic [AW-1:0] i_wdata,
   input  wire logic [PW-1:0] i_ridx,
   output logic      [AW-1:0] o_rdata
);
   logic [AW-1:0] mem [DEPTH];

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < DEPTH; k++) mem[k] <= '0;
      end else if (i_we) begin
         mem[i_widx] <= i_wdata;
      end
   end
   assign o_rdata = mem[i_ridx];
endmodule : bcpu_ras

// [src/bcpu_bus.sv]
// bcpu_bus: one external transfer per start, request/done handshake to pins
// assumes: op_done_n returns high before the next transfer reaches request
`timescale 1ns/1ps
module bcpu_bus import bcpu_pkg::*; (
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   input  wire bcpu_req_t  i_req,
   input  wire logic       i_bus_float_n,
   input  wire logic       i_op_done_n,
   input  wire logic [7:0] i_dbus,
   output logic            o_done,
   output logic      [7:0] o_rdata,
   output bcpu_req_t       o_req,
   output logic            o_op_request,
   output logic            o_write_strobe,
   output logic            o_vector_ack,
   output logic            o_bus_oe_n,
   output logic            o_dbus_oe_n
);
   bcpu_bst_t  st, n_st;
   bcpu_req_t  rq, n_rq;
   logic [7:0] rd, n_rd;
   logic       n_opr, n_wrs, n_vack, n_boe_n, n_doe_n;

   always_comb begin
      n_st = st;
      n_rq = rq;
      n_rd = rd;
      case (st)
         B_IDLE:  if (i_start) begin
            n_rq = i_req;
            n_st = B_SETUP;
         end
         B_SETUP: n_st = B_REQ;
         B_REQ:   if (!i_op_done_n) begin
            n_rd = i_dbus;
            n_st = B_END;
         end
         B_END:   n_st = B_IDLE;
         default: n_st = B_IDLE;
      endcase
      // request only after a full cycle of settled address and control
      n_opr   = (n_st == B_REQ);
      n_wrs   = n_rq.wr ? (n_st == B_END) : (n_st == B_REQ);
      n_vack  = n_rq.vack && (n_st != B_IDLE);
      n_boe_n = ~i_bus_float_n;
      n_doe_n = ~(i_bus_float_n && n_rq.wr && (n_st != B_IDLE));
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st             <= B_IDLE;
         rq             <= '0;
         rd             <= 8'h00;
         o_op_request   <= 1'b0;
         o_write_strobe <= 1'b0;
         o_vector_ack   <= 1'b0;
         o_bus_oe_n     <= 1'b0;
         o_dbus_oe_n    <= 1'b1;
      end else begin
         st             <= n_st;
         rq             <= n_rq;
         rd             <= n_rd;
         o_op_request   <= n_opr;
         o_write_strobe <= n_wrs;
         o_vector_ack   <= n_vack;
         o_bus_oe_n     <= n_boe_n;
         o_dbus_oe_n    <= n_doe_n;
      end
   end
   assign o_done  = (st == B_END);
   assign o_rdata = rd;
   assign o_req   = rq;
endmodule : bcpu_bus

// [src/bcpu_core.sv]
// bcpu_core: 8-bit processor core with its external bus, status word, stack
// assumes: memory and I/O answer each request by pulling op_done_n low
`timescale 1ns/1ps
module bcpu_core import bcpu_pkg::*; #(
   parameter logic LATE_VARIANT = 1'b1
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_dbus,
   input  wire logic        i_op_done_n,
   input  wire logic        i_irq_n,
   input  wire logic        i_pause_n,
   input  wire logic        i_sense,
   input  wire logic        i_bus_float_n,
   output logic      [12:0] o_addr,
   output logic             o_ext_io_sel,
   output logic             o_data_ctrl_sel,
   output logic             o_bus_oe_n,
   output logic      [7:0]  o_dbus,
   output logic             o_dbus_oe_n,
   output logic             o_mem_io,
   output logic             o_read_write,
   output logic             o_op_request,
   output logic             o_write_strobe,
   output logic             o_vector_ack,
   output logic             o_final_cycle,
   output logic             o_flag,
   output logic             o_run
);
   bcpu_st_t    st, n_st;
   logic [7:0]  ir, n_ir, b2, n_b2, b3, n_b3, din, n_din, status_lower_byte, n_psl;
   logic [6:0]  status_upper_byte, n_psu;
   logic [14:0] next_instr_address, n_iar, inc, rel_t, abs_t, babs, stk_rd;
   logic        iss, n_iss, hlt, n_hlt, fin, run;
   logic [7:0]  gpr [NREG];
   logic        we, push, pop, start, bdone;
   logic [2:0]  widx, rsel;
   logic [7:0]  wval, brd, rv, r0, r3, psu_full;
   bcpu_req_t   req, bq;
   logic [2:0]  alu;
   logic [1:0]  md, rf;
   logic [5:0]  g;
   logic        alu_ok, is_halt, io_ne, io_e, io_wr, cond_ok, lt;
   logic [6:0]  wmask;
   logic [7:0]  a, b, res, tst;
   logic [8:0]  s9, d9;
   logic [4:0]  h5, e5;
   logic        cin, bin;

   function automatic logic [1:0] blen(input logic [7:0] o);
      logic ar;
      ar = ~o[4] && (o != OP_HALT) && (o != OP_NOP);
      if ((ar && o[3:2] == M_A) || o[7:2] == G_BCTA || o == OP_BSXA) blen = 2'h3;
      else if ((ar && o[3:2] inside {M_I, M_R}) ||
               o[7:2] inside {G_BCTR, G_REDE, G_WRTE, G_CPPS} ||
               o inside {OP_TPSU, OP_TPSL}) blen = 2'h2;
      else blen = 2'h1;
   endfunction : blen

   function automatic logic needd(input logic [7:0] o);
      needd = (~o[4] && (o != OP_HALT) && (o != OP_NOP) && o[3]) ||
              o[7:2] inside {G_REDC, G_REDD, G_WRTC, G_WRTD, G_REDE, G_WRTE};
   endfunction : needd

   function automatic logic [2:0] ridx(input logic [1:0] r, input logic rs);
      ridx = (r == 2'h0) ? 3'h0 : (rs ? 3'(r) + 3'h3 : 3'(r));
   endfunction : ridx

   function automatic logic [1:0] cc_of(input logic [7:0] v);
      cc_of = (v == 8'h00) ? CC_ZERO : (v[7] ? CC_NEG : CC_POS);
   endfunction : cc_of

   // decode of the first byte: op field, mode and register field
   assign alu      = ir[7:5];
   assign md       = ir[3:2];
   assign rf       = ir[1:0];
   assign g        = ir[7:2];
   assign is_halt  = (ir == OP_HALT);
   assign alu_ok   = ~ir[4] && !is_halt && (ir != OP_NOP);
   assign io_ne    = g inside {G_REDC, G_REDD, G_WRTC, G_WRTD};
   assign io_e     = g inside {G_REDE, G_WRTE};
   assign io_wr    = g inside {G_WRTC, G_WRTD, G_WRTE};
   assign rsel     = ridx(rf, status_lower_byte[PSL_RS]);
   assign rv       = gpr[rsel];
   assign r0       = gpr[0];
   assign r3       = gpr[ridx(2'h3, status_lower_byte[PSL_RS])];
   assign psu_full = {i_sense, status_upper_byte};
   assign wmask    = LATE_VARIANT ? PSU_WM_LATE : PSU_WM_EARLY;
   assign cond_ok  = (rf == CC_ALWAYS) || (status_lower_byte[PSL_CC+:2] == rf);
   // sequential and relative addresses stay inside the current page
   assign inc      = {next_instr_address[14:13], next_instr_address[12:0] + 13'h0001};
   assign rel_t    = {next_instr_address[14:13], next_instr_address[12:0] + {{6{b2[6]}}, b2[6:0]}};
   assign abs_t    = {next_instr_address[14:13], b2[4:0], b3};
   assign babs     = {b2[6:0], b3};

   // arithmetic unit
   always_comb begin
      a   = (md == M_Z) ? r0 : rv;
      b   = (md == M_Z) ? rv : ((md == M_I) ? b2 : din);
      cin = status_lower_byte[PSL_WC] & status_lower_byte[PSL_C];
      bin = status_lower_byte[PSL_WC] & ~status_lower_byte[PSL_C];
      s9  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h5  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      d9  = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      e5  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      case (alu)
         A_EOR:   res = a ^ b;
         A_AND:   res = a & b;
         A_IOR:   res = a | b;
         A_ADD:   res = s9[7:0];
         A_SUB:   res = d9[7:0];
         A_STR:   res = a;
         default: res = b;
      endcase
      lt  = status_lower_byte[PSL_COM] ? (a < b) : ($signed(a) < $signed(b));
      tst = ir[0] ? status_lower_byte : psu_full;
   end

   // request handed to the bus sequencer for the current state
   always_comb begin
      req = {next_instr_address, 1'b1, 1'b0, 1'b0, rv};
      if (st == S_DATA) begin
         if (io_ne) begin
            req.addr = {(g inside {G_REDD, G_WRTD}) ? DC_DATA : DC_CTRL,
                        IO_NONEXT, 13'h0000};
            req.mem  = 1'b0;
            req.wr   = io_wr;
         end else if (io_e) begin
            req.addr = {DC_CTRL, IO_EXT, 5'h00, b2};
            req.mem  = 1'b0;
            req.wr   = io_wr;
         end else begin
            req.addr = (md == M_R) ? rel_t : abs_t;
            req.wr   = (alu == A_STR);
         end
      end else if (st == S_VECT) begin
         req.addr = 15'h0000;
         req.mem  = 1'b0;
         req.vack = 1'b1;
      end
   end

   always_comb begin
      n_st  = st;
      n_ir  = ir;
      n_b2  = b2;
      n_b3  = b3;
      n_din = din;
      n_iar = next_instr_address;
      n_psu = status_upper_byte;
      n_psl = status_lower_byte;
      n_iss = iss;
      n_hlt = hlt;
      start = 1'b0;
      we    = 1'b0;
      widx  = rsel;
      wval  = res;
      push  = 1'b0;
      pop   = 1'b0;
      if (st != S_EXEC && st != S_HALT) begin
         if (!iss) begin
            start = 1'b1;
            n_iss = 1'b1;
         end else if (bdone) begin
            n_iss = 1'b0;
         end
      end
      case (st)
         S_FETCH: if (iss && bdone) begin
            n_ir  = brd;
            n_iar = inc;
            n_st  = (blen(brd) != 2'h1) ? S_B2 : (needd(brd) ? S_DATA : S_EXEC);
         end
         S_B2: if (iss && bdone) begin
            n_b2  = brd;
            n_iar = inc;
            n_st  = (blen(ir) == 2'h3) ? S_B3 : (needd(ir) ? S_DATA : S_EXEC);
         end
         S_B3: if (iss && bdone) begin
            n_b3  = brd;
            n_iar = inc;
            n_st  = needd(ir) ? S_DATA : S_EXEC;
         end
         S_DATA: if (iss && bdone) begin
            n_din = brd;
            n_st  = S_EXEC;
         end
         S_VECT: if (iss && bdone) begin
            push  = 1'b1;
            n_iar = {{8{brd[6]}}, brd[6:0]};
            n_st  = S_FETCH;
         end
         S_HALT: begin
            if (!i_irq_n && !status_upper_byte[PSU_II]) begin
               n_psu[PSU_II] = 1'b1;
               n_hlt         = 1'b0;
               n_st          = S_VECT;
            end else if (!hlt && i_pause_n) begin
               n_st = S_FETCH;
            end
         end
         S_EXEC: begin
            if (alu_ok) begin
               if (alu == A_COM) begin
                  n_psl[PSL_CC+:2] = (a == b) ? CC_ZERO : (lt ? CC_NEG : CC_POS);
               end else if (alu == A_STR) begin
                  we   = (md == M_Z);
                  wval = r0;
               end else begin
                  we               = 1'b1;
                  widx             = (md == M_Z) ? 3'h0 : rsel;
                  n_psl[PSL_CC+:2] = cc_of(res);
                  if (alu == A_ADD) begin
                     n_psl[PSL_C]   = s9[8];
                     n_psl[PSL_IDC] = h5[4];
                     n_psl[PSL_OVF] = (a[7] == b[7]) && (s9[7] != a[7]);
                  end else if (alu == A_SUB) begin
                     n_psl[PSL_C]   = ~d9[8];
                     n_psl[PSL_IDC] = ~e5[4];
                     n_psl[PSL_OVF] = (a[7] != b[7]) && (d9[7] != a[7]);
                  end
               end
            end else if (ir == OP_SPSU || ir == OP_SPSL) begin
               we               = 1'b1;
               widx             = 3'h0;
               wval             = ir[0] ? status_lower_byte : psu_full;
               n_psl[PSL_CC+:2] = cc_of(wval);
            end else if (ir == OP_LPSU) begin
               n_psu = (r0[6:0] & wmask) | (status_upper_byte & ~wmask);
            end else if (ir == OP_LPSL) begin
               n_psl = r0;
            end else if (g == G_CPPS) begin
               if (!ir[0]) n_psu = ir[1] ? (status_upper_byte | (b2[6:0] & wmask)) : (status_upper_byte & ~(b2[6:0] & wmask));
               else n_psl = ir[1] ? (status_lower_byte | b2) : (status_lower_byte & ~b2);
            end else if (ir == OP_TPSU || ir == OP_TPSL) begin
               n_psl[PSL_CC+:2] = ((tst & b2) == b2) ? CC_ZERO : CC_NEG;
            end else if (g == G_RETC || g == G_RETE) begin
               if (cond_ok) begin
                  pop = 1'b1;
                  if (g == G_RETE) n_psu[PSU_II] = 1'b0;
               end
            end else if (g == G_BCTA) begin
               if (cond_ok) n_iar = babs;
            end else if (g == G_BCTR) begin
               if (cond_ok) n_iar = rel_t;
            end else if (ir == OP_BSXA) begin
               push  = 1'b1;
               n_iar = babs + {7'h00, r3};
            end else if (g inside {G_REDC, G_REDD, G_REDE}) begin
               we               = 1'b1;
               wval             = din;
               n_psl[PSL_CC+:2] = cc_of(din);
            end
         end
         default: n_st = S_FETCH;
      endcase
      // pointer wraps through the eight levels
      if (push) n_psu[2:0] = status_upper_byte[2:0] + 3'h1;
      if (pop) begin
         n_iar      = stk_rd;
         n_psu[2:0] = status_upper_byte[2:0] - 3'h1;
      end
      // the inhibit written by this instruction decides the interrupt
      if (st == S_EXEC) begin
         if (!i_irq_n && !n_psu[PSU_II]) begin
            n_psu[PSU_II] = 1'b1;
            n_st          = S_VECT;
         end else if (is_halt || !i_pause_n) begin
            n_hlt = is_halt;
            n_st  = S_HALT;
         end else begin
            n_st = S_FETCH;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st  <= S_FETCH;
         ir  <= 8'h00;
         b2  <= 8'h00;
         b3  <= 8'h00;
         din <= 8'h00;
         next_instr_address <= RST_IAR;
         status_upper_byte <= LATE_VARIANT ? PSU_RST_LATE : PSU_RST_EARLY;
         status_lower_byte <= RST_PSL;
         iss <= 1'b0;
         hlt <= 1'b0;
         fin <= 1'b0;
         run <= 1'b1;
      end else begin
         st  <= n_st;
         ir  <= n_ir;
         b2  <= n_b2;
         b3  <= n_b3;
         din <= n_din;
         next_instr_address <= n_iar;
         status_upper_byte <= n_psu;
         status_lower_byte <= n_psl;
         iss <= n_iss;
         hlt <= n_hlt;
         fin <= (n_st == S_EXEC);
         run <= (n_st != S_HALT);
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < NREG; k++) gpr[k] <= 8'h00;
      end else if (we) begin
         gpr[widx] <= wval;
      end
   end

   bcpu_ras #(.DEPTH(8), .AW(ADDR_W), .PW(3)) u_ras (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_we    (push),
      .i_widx  (status_upper_byte[2:0] + 3'h1),
      .i_wdata (next_instr_address),
      .i_ridx  (status_upper_byte[2:0]),
      .o_rdata (stk_rd)
   );

   bcpu_bus u_bus (
      .i_mclk         (i_mclk),
      .i_rst          (i_rst),
      .i_start        (start),
      .i_req          (req),
      .i_bus_float_n  (i_bus_float_n),
      .i_op_done_n    (i_op_done_n),
      .i_dbus         (i_dbus),
      .o_done         (bdone),
      .o_rdata        (brd),
      .o_req          (bq),
      .o_op_request   (o_op_request),
      .o_write_strobe (o_write_strobe),
      .o_vector_ack   (o_vector_ack),
      .o_bus_oe_n     (o_bus_oe_n),
      .o_dbus_oe_n    (o_dbus_oe_n)
   );

   assign o_addr          = bq.addr[12:0];
   assign o_ext_io_sel    = bq.addr[13];
   assign o_data_ctrl_sel = bq.addr[14];
   assign o_dbus          = bq.wdata;
   assign o_mem_io        = bq.mem;
   assign o_read_write    = bq.wr;
   assign o_final_cycle   = fin;
   assign o_flag          = status_upper_byte[PSU_FLAG];
   assign o_run           = run;
endmodule : bcpu_core

// [tb/bcpu_core_chk.sv]
// bcpu_core_chk: handshake, strobe and float properties on the core pins
// assumes: bound to bcpu_core, sees only its ports
`timescale 1ns/1ps
module bcpu_core_chk (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_op_done_n,
   input wire logic        i_bus_float_n,
   input wire logic [12:0] o_addr,
   input wire logic [7:0]  o_dbus,
   input wire logic        o_dbus_oe_n,
   input wire logic        o_bus_oe_n,
   input wire logic        o_mem_io,
   input wire logic        o_read_write,
   input wire logic        o_op_request,
   input wire logic        o_write_strobe,
   input wire logic        o_vector_ack,
   input wire logic        o_final_cycle
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_req_hold: assert property (o_op_request && i_op_done_n |=> o_op_request
      && $stable(o_addr) && $stable(o_read_write) && $stable(o_dbus)) else $error("bus moved");
   a_req_end: assert property (o_op_request && !i_op_done_n |=> !o_op_request)
      else $error("request outlived done");
   a_req_gap: assert property ($fell(o_op_request) |-> !o_op_request [*3])
      else $error("request without setup");
   a_read_strobe: assert property (o_op_request && !o_read_write |-> o_write_strobe)
      else $error("strobe low on read");
   a_write_pulse: assert property ($fell(o_op_request) && o_read_write
      |-> o_write_strobe ##1 !o_write_strobe) else $error("no single write pulse");
   a_write_data: assert property (o_op_request && o_read_write |-> !o_dbus_oe_n)
      else $error("write data not driven");
   a_bus_float: assert property (!i_bus_float_n |=> o_bus_oe_n && o_dbus_oe_n)
      else $error("bus not floated");
   a_vector_io: assert property (o_vector_ack && o_op_request
      |-> !o_mem_io && !o_read_write) else $error("vector not an io read");
   a_final_single: assert property (o_final_cycle |=> !o_final_cycle)
      else $error("final cycle held");
   a_final_idle: assert property (o_final_cycle |-> !o_op_request)
      else $error("final cycle during request");
   c_write: cover property (o_op_request && o_read_write);
   c_vector: cover property (o_vector_ack && o_op_request);
   c_float: cover property (!i_bus_float_n);
endmodule : bcpu_core_chk
bind bcpu_core bcpu_core_chk chk_i (.*);

// [tb/bcpu_mem_model.sv]
// bcpu_mem_model: memory and io ports answering the request handshake
// assumes: program, vector byte and io read byte are loaded by the bench
`timescale 1ns/1ps
module bcpu_mem_model (
   input  wire logic       i_mclk,
   input  wire logic       i_req,
   input  wire logic       i_mem,
   input  wire logic       i_vack,
   input  wire logic [7:0] i_addr,
   input  wire logic [2:0] i_lat,
   output logic            o_done_n,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] vec;
   logic [7:0] io_in;
   logic [2:0] cnt = 3'h0;
   initial o_done_n = 1'b1;
   initial o_rdata = 8'h5A;
   always @(posedge i_mclk) begin
      if (i_req !== 1'b1) begin
         // released bus keeps changing so a stale byte is never read
         o_done_n <= 1'b1;
         o_rdata  <= ~o_rdata;
         cnt      <= 3'h0;
      end else if (o_done_n && cnt >= i_lat) begin
         o_done_n <= 1'b0;
         o_rdata  <= i_vack ? vec : (i_mem ? mem[i_addr] : io_in);
      end else if (o_done_n) begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule : bcpu_mem_model

// [tb/bcpu_core_bench.sv]
// bcpu_core_bench: runs a short io and status program through the core
// assumes: bcpu_mem_model answers each request, program in page 0
`timescale 1ns/1ps
module bcpu_core_bench;
   import bcpu_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, irq_n = 1'b1, float_n = 1'b1, done_n;
   logic        sense = 1'b1, pause_n = 1'b1;
   logic [2:0]  lat = 3'h0;
   logic [7:0]  rdata, wdata;
   logic [12:0] addr;
   logic        ext, dcs, bus_oe_n, dbus_oe_n, mem_io, rw, req, write_strobe, vack, flag, run;
   int          n_errors = 0, n_compared = 0;
   logic [7:0]  prog [0:24] = '{8'h04, 8'hA5, 8'hF0, 8'hD4, 8'h3C, 8'h54, 8'h5A, 8'hF0,
      8'h04, 8'h40, 8'h92, 8'h12, 8'hF0, 8'h40, 8'hC0, 8'hC0, 8'h12, 8'hF0, 8'h04, 8'h7F,
      8'h84, 8'h01, 8'h13, 8'hF0, 8'h40};
   always #5 clk = ~clk;
   bcpu_core bcpu_core_i (.i_mclk(clk), .i_rst(rst), .i_dbus(rdata), .i_op_done_n(done_n),
      .i_irq_n(irq_n), .i_pause_n(pause_n), .i_sense(sense), .i_bus_float_n(float_n),
      .o_addr(addr), .o_ext_io_sel(ext), .o_data_ctrl_sel(dcs), .o_bus_oe_n(bus_oe_n),
      .o_dbus(wdata), .o_dbus_oe_n(dbus_oe_n), .o_mem_io(mem_io), .o_read_write(rw),
      .o_op_request(req), .o_write_strobe(write_strobe), .o_vector_ack(vack), .o_final_cycle(),
      .o_flag(flag), .o_run(run));
   bcpu_mem_model bcpu_mem_model_i (.i_mclk(clk), .i_req(req), .i_mem(mem_io),
      .i_vack(vack), .i_addr(addr[7:0]), .i_lat(lat), .o_done_n(done_n), .o_rdata(rdata));
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         n_errors++;
      end
   endtask : check
   // next io or vector transfer; a leftover request is let go first
   task automatic io_xfer;
      int k;
      k = 0;
      while (req === 1'b1 && k < 400) begin @(posedge clk); #1; k++; end
      while (!(req === 1'b1 && mem_io === 1'b0) && k < 400) begin @(posedge clk); #1; k++; end
      check(k < 400, 1'b1);
   endtask : io_xfer
   task automatic wait_halt;
      for (int k = 0; k < 300 && run !== 1'b0; k++) @(posedge clk);
      #1;
      check(run, 1'b0);
   endtask : wait_halt
   task automatic t_reset_fetch;
      // reset first takes hold at a clock edge, so look only after two of them
      repeat (2) @(posedge clk);
      #1;
      check({run, req, write_strobe, vack}, 4'b1000);
      @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 20 && req !== 1'b1; k++) @(posedge clk);
      #1;
      check(addr, 13'h0000);
      check({ext, dcs, mem_io, rw, write_strobe}, 5'b00101);
   endtask : t_reset_fetch
   task automatic t_io_writes;
      io_xfer;
      check({wdata, rw, dcs, ext}, {8'hA5, 1'b1, DC_DATA, IO_NONEXT});
      @(posedge clk);
      lat <= 3'h2;
      io_xfer;
      check({addr[7:0], ext, dcs}, {8'h3C, IO_EXT, 1'b0});
      check(wdata, 8'hA5);
   endtask : t_io_writes
   task automatic t_io_read;
      io_xfer;
      check({addr[7:0], rw, write_strobe, ext}, {8'h5A, 1'b0, 1'b1, IO_EXT});
      // pause lands while the read instruction is still running
      @(posedge clk);
      pause_n <= 1'b0;
      wait_halt;
      repeat (5) @(posedge clk);
      #1;
      check({run, req}, 2'b00);
      @(posedge clk);
      pause_n <= 1'b1;
      io_xfer;
      check(wdata, 8'h69);
      check(run, 1'b1);
   endtask : t_io_read
   task automatic t_status;
      io_xfer;
      check({wdata, flag}, {8'hC0, 1'b1});
      @(posedge clk);
      lat <= 3'h0;
   endtask : t_status
   task automatic t_halt_float;
      wait_halt;
      @(posedge clk);
      float_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({bus_oe_n, dbus_oe_n}, 2'b11);
      @(posedge clk);
      float_n <= 1'b1;
   endtask : t_halt_float
   task automatic t_interrupt;
      @(posedge clk);
      irq_n <= 1'b0;
      sense <= 1'b0;
      io_xfer;
      check({vack, rw, mem_io}, 3'b100);
      io_xfer;
      check(wdata, 8'h61);
      io_xfer;
      check(wdata, 8'hA4);
      wait_halt;
      repeat (40) begin @(posedge clk); #1; check({run, vack}, 2'b00); end
   endtask : t_interrupt
   task automatic give_verdict;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      for (int k = 0; k < 256; k++) bcpu_mem_model_i.mem[k] = OP_NOP;
      for (int k = 0; k < 25; k++) bcpu_mem_model_i.mem[k] = prog[k];
      bcpu_mem_model_i.vec = 8'h10;
      bcpu_mem_model_i.io_in = 8'h69;
      t_reset_fetch;
      t_io_writes;
      t_io_read;
      t_status;
      t_halt_float;
      t_interrupt;
      give_verdict;
   end
   initial begin
      #200000;
      n_errors++;
      give_verdict;
   end
endmodule : bcpu_core_bench
